//--- design/rpia_controller.sv
// Interrupt pending, mode, mask and two-level rotating arbitration behind AHB-Lite
// Contract
// - Seven arbiters resolve 32 requests: six first-level feed one second-level.
// - Each arbiter has six inputs, one rotate enable, one two-bit order select.
// - Order select 00,01,10,11 rotates inputs one to four after input zero.
// - Input zero always wins, input five always loses, in every arbiter.
// - Rotate enable zero: hardware never changes the order select; software still can.
// - Rotate enable one: serviced input 1..4 sets select to 01,10,11,00.
// - Servicing input zero or five leaves the order select unchanged.
// - Requests latch first, split by mode; only normal ones are arbitrated.
// - A request sets its latch bit regardless of mask and arbitration.
// - Any set latch bit counts as an outstanding request.
// - Writing the latch clears bits written one, keeps bits written zero.
// - Latch resets to zero; reads one for requested sources.
// - Latch holds 32 positions; positions 24 and 6 are unused.
// - Mode bit one means fast interrupt, zero means normal interrupt.
// - Fast sources never reach the winner pending or winner index registers.
// - Mode register resets to zero.
// - Masked sources are not serviced but still latch; mask resets to ones.
// - Winner pending holds at most one bit, the current normal winner.
// - Priority control resets with rotation on and all selects zero.
`timescale 1ns/1ps
module rpia_controller (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [31:0] i_source_req,
  output logic o_fiq,
  output logic o_irq
);

  logic [31:0] src_reg, src_next;
  logic [31:0] mode_reg, mode_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] winpnd_reg, winpnd_next;
  logic [4:0] winidx_reg, winidx_next;
  logic [2:0] wgrp_reg, wgrp_next;
  logic [2:0] wpos_reg, wpos_next;
  logic [20:0] prio_reg, prio_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [31:0] daddr_reg, daddr_next;
  logic dwr_reg, dwr_next;
  logic fiq_reg, fiq_next;
  logic irq_reg, irq_next;

  logic addr_take;
  logic wr_src, wr_mode, wr_mask, wr_prio, wr_winpnd;
  logic [31:0] req_valid;
  logic [31:0] normal_cand;
  logic [31:0] winpnd_clr;
  logic [31:0] winpnd_after;
  logic served;
  logic [5:0] l1_req [rpia_pkg::GROUPS];
  logic [5:0] l1_valid;
  logic [2:0] l1_index [rpia_pkg::GROUPS];
  logic l2_valid;
  logic [2:0] l2_index;
  logic [2:0] l1_win_pos;
  logic [4:0] win_src;

  // ****************************************
  // AHB-Lite decode
  // ****************************************
  assign addr_take = i_hsel && i_hready && i_htrans[1];
  assign wr_src = dwr_reg && (daddr_reg == rpia_pkg::OFF_SOURCE_REQUEST_LATCH);
  assign wr_mode = dwr_reg && (daddr_reg == rpia_pkg::OFF_FAST_SELECT_MAP);
  assign wr_mask = dwr_reg && (daddr_reg == rpia_pkg::OFF_SOURCE_MASK);
  assign wr_prio = dwr_reg && (daddr_reg == rpia_pkg::OFF_PRIORITY_CONTROL);
  assign wr_winpnd = dwr_reg && (daddr_reg == rpia_pkg::OFF_WINNER_PENDING);
  assign o_hreadyout = 1'b1;
  assign o_hresp = rpia_pkg::HRESP_OKAY;
  assign o_hrdata = hrdata_reg;
  assign o_fiq = fiq_reg;
  assign o_irq = irq_reg;

  // ****************************************
  // Request split
  // ****************************************
  assign req_valid = i_source_req & rpia_pkg::SOURCE_VALID;
  assign normal_cand = src_reg & ~mask_reg & ~mode_reg & rpia_pkg::SOURCE_VALID;

  // ****************************************
  // Two-level arbitration
  // ****************************************
  genvar g, p;
  generate
    for (g = 0; g < rpia_pkg::GROUPS; g++) begin : gen_l1
      for (p = 0; p < rpia_pkg::ARB_INPUTS; p++) begin : gen_in
        if (p >= rpia_pkg::GRP_FIRST[g] && p < rpia_pkg::GRP_FIRST[g] + rpia_pkg::GRP_COUNT[g]) begin : gen_used
          assign l1_req[g][p] = normal_cand[rpia_pkg::GRP_BASE[g] + p - rpia_pkg::GRP_FIRST[g]];
        end else begin : gen_tied
          assign l1_req[g][p] = 1'b0;
        end
      end
      rpia_arbiter u_arb (
        .i_req(l1_req[g]),
        .i_sel(prio_reg[rpia_pkg::PRIO_SEL_LSB + rpia_pkg::PRIO_SEL_WIDTH * g +: rpia_pkg::PRIO_SEL_WIDTH]),
        .o_valid(l1_valid[g]),
        .o_index(l1_index[g])
      );
    end
  endgenerate

  rpia_arbiter u_arb_top (
    .i_req(l1_valid),
    .i_sel(prio_reg[rpia_pkg::PRIO_SEL_LSB + rpia_pkg::PRIO_SEL_WIDTH * rpia_pkg::TOP_ARBITER +:
                    rpia_pkg::PRIO_SEL_WIDTH]),
    .o_valid(l2_valid),
    .o_index(l2_index)
  );

  always_comb begin
    l1_win_pos = l1_index[l2_index];
    win_src = 5'(rpia_pkg::GRP_BASE[l2_index] + int'(l1_win_pos) - rpia_pkg::GRP_FIRST[l2_index]);
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    src_next = (src_reg & ~(wr_src ? i_hwdata : rpia_pkg::ZERO_WORD)) | req_valid;
    mode_next = wr_mode ? i_hwdata : mode_reg;
    mask_next = wr_mask ? i_hwdata : mask_reg;
    winpnd_clr = wr_winpnd ? i_hwdata : rpia_pkg::ZERO_WORD;
    served = |(winpnd_reg & winpnd_clr);
    winpnd_after = winpnd_reg & ~winpnd_clr;
    winpnd_next = winpnd_after;
    winidx_next = winidx_reg;
    wgrp_next = wgrp_reg;
    wpos_next = wpos_reg;
    if (winpnd_after == rpia_pkg::ZERO_WORD && l2_valid) begin
      winpnd_next = 32'(1) << win_src;
      winidx_next = win_src;
      wgrp_next = l2_index;
      wpos_next = l1_win_pos;
    end
    prio_next = prio_reg;
    if (served) begin
      if (prio_reg[wgrp_reg] && wpos_reg >= rpia_pkg::REQ_ROT_LOW && wpos_reg <= rpia_pkg::REQ_ROT_HIGH) begin
        prio_next[rpia_pkg::PRIO_SEL_LSB + rpia_pkg::PRIO_SEL_WIDTH * int'(wgrp_reg) +: rpia_pkg::PRIO_SEL_WIDTH] =
          wpos_reg[1:0];
      end
      if (prio_reg[rpia_pkg::TOP_ARBITER] && wgrp_reg >= rpia_pkg::REQ_ROT_LOW &&
          wgrp_reg <= rpia_pkg::REQ_ROT_HIGH) begin
        prio_next[rpia_pkg::PRIO_SEL_LSB + rpia_pkg::PRIO_SEL_WIDTH * rpia_pkg::TOP_ARBITER +:
                  rpia_pkg::PRIO_SEL_WIDTH] = wgrp_reg[1:0];
      end
    end
    if (wr_prio) begin
      prio_next = i_hwdata[rpia_pkg::PRIO_WIDTH-1:0];
    end
    fiq_next = |(src_reg & mode_reg & ~mask_reg & rpia_pkg::SOURCE_VALID);
    irq_next = |normal_cand;
    dwr_next = addr_take && i_hwrite;
    daddr_next = addr_take ? i_haddr : daddr_reg;
    hrdata_next = hrdata_reg;
    if (addr_take && !i_hwrite) begin
      case (i_haddr)
        rpia_pkg::OFF_SOURCE_REQUEST_LATCH: hrdata_next = src_next;
        rpia_pkg::OFF_FAST_SELECT_MAP: hrdata_next = mode_next;
        rpia_pkg::OFF_SOURCE_MASK: hrdata_next = mask_next;
        rpia_pkg::OFF_PRIORITY_CONTROL: hrdata_next = 32'(prio_next);
        rpia_pkg::OFF_WINNER_PENDING: hrdata_next = winpnd_next;
        rpia_pkg::OFF_WINNER_INDEX: hrdata_next = 32'(winidx_next);
        default: hrdata_next = rpia_pkg::ZERO_WORD;
      endcase
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      src_reg <= rpia_pkg::SOURCE_LATCH_RESET;
      mode_reg <= rpia_pkg::FAST_MAP_RESET;
      mask_reg <= rpia_pkg::MASK_RESET;
      winpnd_reg <= rpia_pkg::WINNER_PENDING_RESET;
      winidx_reg <= rpia_pkg::WINNER_INDEX_RESET;
      wgrp_reg <= rpia_pkg::REQ_FIRST;
      wpos_reg <= rpia_pkg::REQ_FIRST;
      prio_reg <= rpia_pkg::PRIO_RESET;
      hrdata_reg <= rpia_pkg::ZERO_WORD;
      daddr_reg <= rpia_pkg::ZERO_WORD;
      dwr_reg <= 1'b0;
      fiq_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      winpnd_reg <= winpnd_next;
      winidx_reg <= winidx_next;
      wgrp_reg <= wgrp_next;
      wpos_reg <= wpos_next;
      prio_reg <= prio_next;
      hrdata_reg <= hrdata_next;
      daddr_reg <= daddr_next;
      dwr_reg <= dwr_next;
      fiq_reg <= fiq_next;
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [1:0] top_sel;
  logic top_rot;
  assign top_sel = prio_reg[rpia_pkg::PRIO_SEL_LSB + rpia_pkg::PRIO_SEL_WIDTH * rpia_pkg::TOP_ARBITER +:
                            rpia_pkg::PRIO_SEL_WIDTH];
  assign top_rot = prio_reg[rpia_pkg::TOP_ARBITER];

  property p_src_set;
    @(posedge i_clock) disable iff (!i_rst_b)
      req_valid != rpia_pkg::ZERO_WORD |=> (src_reg & $past(req_valid)) == $past(req_valid);
  endproperty
  a_src_set: assert property (p_src_set) else $error("source request not latched");

  property p_src_clear;
    @(posedge i_clock) disable iff (!i_rst_b)
      wr_src |=> src_reg == (($past(src_reg) & ~$past(i_hwdata)) | $past(req_valid));
  endproperty
  a_src_clear: assert property (p_src_clear) else $error("latch clear wrong");

  property p_src_reserved;
    @(posedge i_clock) disable iff (!i_rst_b)
      (src_reg & ~rpia_pkg::SOURCE_VALID) == rpia_pkg::ZERO_WORD;
  endproperty
  a_src_reserved: assert property (p_src_reserved) else $error("reserved latch bit set");

  property p_winner_onehot;
    @(posedge i_clock) disable iff (!i_rst_b)
      $onehot0(winpnd_reg) && (winpnd_reg == rpia_pkg::ZERO_WORD || winpnd_reg[winidx_reg]);
  endproperty
  a_winner_onehot: assert property (p_winner_onehot) else $error("winner pending not one-hot");

  property p_winner_normal;
    @(posedge i_clock) disable iff (!i_rst_b)
      (winpnd_reg != rpia_pkg::ZERO_WORD) && ($past(winpnd_reg) == rpia_pkg::ZERO_WORD)
        |->
        (winpnd_reg & ($past(mode_reg) | $past(mask_reg))) == rpia_pkg::ZERO_WORD;
  endproperty
  a_winner_normal: assert property (p_winner_normal) else $error("fast or masked source won");

  property p_top_first;
    @(posedge i_clock) disable iff (!i_rst_b)
      l1_valid[0] |-> l2_index == rpia_pkg::REQ_FIRST;
  endproperty
  a_top_first: assert property (p_top_first) else $error("input zero lost");

  property p_top_last;
    @(posedge i_clock) disable iff (!i_rst_b)
      (l2_index == rpia_pkg::REQ_LAST) |-> (l1_valid == 6'h20);
  endproperty
  a_top_last: assert property (p_top_last) else $error("input five won over another");

  property p_fixed_sel;
    @(posedge i_clock) disable iff (!i_rst_b)
      (!top_rot && !wr_prio) |=> top_sel == $past(top_sel);
  endproperty
  a_fixed_sel: assert property (p_fixed_sel) else $error("fixed order select changed");

  property p_rotate;
    @(posedge i_clock) disable iff (!i_rst_b)
      (served && top_rot && !wr_prio && wgrp_reg >= rpia_pkg::REQ_ROT_LOW && wgrp_reg <= rpia_pkg::REQ_ROT_HIGH)
        |=> top_sel == $past(wgrp_reg[1:0]);
  endproperty
  a_rotate: assert property (p_rotate) else $error("order select not rotated");

  property p_edge_keep;
    @(posedge i_clock) disable iff (!i_rst_b)
      (served && !wr_prio && (wgrp_reg == rpia_pkg::REQ_FIRST || wgrp_reg == rpia_pkg::REQ_LAST))
        |=> top_sel == $past(top_sel);
  endproperty
  a_edge_keep: assert property (p_edge_keep) else $error("order select moved on edge input");

  property p_fiq;
    @(posedge i_clock) disable iff (!i_rst_b)
      o_fiq == $past(|(src_reg & mode_reg & ~mask_reg));
  endproperty
  a_fiq: assert property (p_fiq) else $error("fast output wrong");

  property p_irq;
    @(posedge i_clock) disable iff (!i_rst_b)
      $past(normal_cand) != rpia_pkg::ZERO_WORD |-> o_irq ##1 (winpnd_reg != rpia_pkg::ZERO_WORD || o_irq);
  endproperty
  a_irq: assert property (p_irq) else $error("normal output missing");

endmodule : rpia_controller

//--- design/rpia_pkg.sv
// Constants shared by the rotating priority interrupt arbiter
package rpia_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [31:0] OFF_SOURCE_REQUEST_LATCH = 32'h4a00_0000;
  localparam logic [31:0] OFF_FAST_SELECT_MAP = 32'h4a00_0004;
  localparam logic [31:0] OFF_SOURCE_MASK = 32'h4a00_0008;
  localparam logic [31:0] OFF_PRIORITY_CONTROL = 32'h4a00_000c;
  localparam logic [31:0] OFF_WINNER_PENDING = 32'h4a00_0010;
  localparam logic [31:0] OFF_WINNER_INDEX = 32'h4a00_0014;

  // ****************************************
  // Reset values and field layouts
  // ****************************************
  localparam logic [31:0] SOURCE_LATCH_RESET = 32'h0000_0000;
  localparam logic [31:0] FAST_MAP_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'hffff_ffff;
  localparam logic [31:0] WINNER_PENDING_RESET = 32'h0000_0000;
  localparam logic [4:0] WINNER_INDEX_RESET = 5'h00;
  localparam int PRIO_WIDTH = 21;
  localparam logic [20:0] PRIO_RESET = 21'h00_007f;
  localparam int PRIO_SEL_LSB = 7;
  localparam int PRIO_SEL_WIDTH = 2;
  localparam int TOP_ARBITER = 6;
  // Positions 24 and 6 are reserved and never latch
  localparam logic [31:0] SOURCE_VALID = 32'hfeff_ffbf;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ****************************************
  // Arbiter shape and source grouping
  // ****************************************
  localparam int ARB_INPUTS = 6;
  localparam int GROUPS = 6;
  localparam int ROTATING = 4;
  localparam logic [2:0] REQ_FIRST = 3'h0;
  localparam logic [2:0] REQ_ROT_LOW = 3'h1;
  localparam logic [2:0] REQ_ROT_HIGH = 3'h4;
  localparam logic [2:0] REQ_LAST = 3'h5;
  // Lowest source of each group and the arbiter input it lands on
  localparam int GRP_BASE [GROUPS] = '{0, 4, 10, 16, 22, 28};
  localparam int GRP_FIRST [GROUPS] = '{1, 0, 0, 0, 0, 1};
  localparam int GRP_COUNT [GROUPS] = '{4, 6, 6, 6, 6, 4};

  // ****************************************
  // Bus constants
  // ****************************************
  localparam logic HRESP_OKAY = 1'b0;

endpackage : rpia_pkg

//--- design/rpia_arbiter.sv
// Six-input arbiter with rotatable middle priority
`timescale 1ns/1ps
module rpia_arbiter (
  input wire logic [5:0] i_req,
  input wire logic [1:0] i_sel,
  output logic o_valid,
  output logic [2:0] o_index
);

  logic found;
  logic [2:0] slot;

  // ****************************************
  // Priority search
  // ****************************************
  always_comb begin
    found = 1'b0;
    slot = rpia_pkg::REQ_FIRST;
    o_index = rpia_pkg::REQ_FIRST;
    o_valid = |i_req;
    if (i_req[rpia_pkg::REQ_FIRST]) begin
      found = 1'b1;
    end
    for (int k = 0; k < rpia_pkg::ROTATING; k++) begin
      slot = 3'((int'(i_sel) + k) % rpia_pkg::ROTATING + int'(rpia_pkg::REQ_ROT_LOW));
      if (!found && i_req[slot]) begin
        o_index = slot;
        found = 1'b1;
      end
    end
    if (!found && i_req[rpia_pkg::REQ_LAST]) begin
      o_index = rpia_pkg::REQ_LAST;
    end
  end

endmodule : rpia_arbiter

//--- test/rpia_core_model.sv
// Processor core model counting fast and normal interrupt entries
`timescale 1ns/1ps
module rpia_core_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_fiq,
  input wire logic i_irq,
  output logic [7:0] o_fiq_entries,
  output logic [7:0] o_irq_entries
);
  // ****************************************
  // Entry counting on each rising request
  // ****************************************
  logic fiq_reg;
  logic irq_reg;
  logic [7:0] fiq_count_next;
  logic [7:0] irq_count_next;
  always_comb begin
    fiq_count_next = o_fiq_entries + {7'h00, (i_fiq & ~fiq_reg)};
    irq_count_next = o_irq_entries + {7'h00, (i_irq & ~irq_reg)};
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fiq_reg <= 1'b0;
      irq_reg <= 1'b0;
      o_fiq_entries <= 8'h00;
      o_irq_entries <= 8'h00;
    end else begin
      fiq_reg <= i_fiq;
      irq_reg <= i_irq;
      o_fiq_entries <= fiq_count_next;
      o_irq_entries <= irq_count_next;
    end
  end
endmodule : rpia_core_model

//--- test/tb.sv
// Testbench for the rotating priority interrupt arbiter
`timescale 1ns/1ps
module tb;
  // ****************************************
  // Signals and design instance
  // ****************************************
  localparam logic [31:0] A_LAT = rpia_pkg::OFF_SOURCE_REQUEST_LATCH;
  localparam logic [31:0] A_MAP = rpia_pkg::OFF_FAST_SELECT_MAP;
  localparam logic [31:0] A_MSK = rpia_pkg::OFF_SOURCE_MASK;
  localparam logic [31:0] A_PRI = rpia_pkg::OFF_PRIORITY_CONTROL;
  localparam logic [31:0] A_WP = rpia_pkg::OFF_WINNER_PENDING;
  localparam logic [31:0] A_WI = rpia_pkg::OFF_WINNER_INDEX;
  logic clock;
  logic rst_b;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] source_req;
  logic fiq;
  logic irq;
  logic [7:0] fiq_entries;
  logic [7:0] irq_entries;
  logic [31:0] rd;
  int fail_count;
  int total_checks;
  int sv [4] = '{1, 2, 3, 0};
  int prev;
  rpia_controller uut (.i_clock(clock), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_source_req(source_req), .o_fiq(fiq), .o_irq(irq));
  rpia_core_model core (.i_clock(clock), .i_rst_b(rst_b), .i_fiq(fiq), .i_irq(irq),
    .o_fiq_entries(fiq_entries), .o_irq_entries(irq_entries));
  // ****************************************
  // Tasks
  // ****************************************
  task results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : wait_ready
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(name, rd, exp);
    check("hresp", {31'h0, hresp}, {31'h0, rpia_pkg::HRESP_OKAY});
    check("hreadyout", {31'h0, hreadyout}, 32'h0000_0001);
  endtask : rchk
  task outs(input logic ef, input logic ei);
    @(negedge clock);
    check("fiq", {31'h0, fiq}, {31'h0, ef});
    check("irq", {31'h0, irq}, {31'h0, ei});
    @(posedge clock);
  endtask : outs
  task pulse(input logic [31:0] v);
    source_req <= v;
    @(posedge clock);
    source_req <= 32'h0000_0000;
    repeat (3) @(posedge clock);
  endtask : pulse
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    source_req = 32'h0000_0000;
    fail_count = 0;
    total_checks = 0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rchk("latch", A_LAT, 32'h0000_0000);
    rchk("map", A_MAP, 32'h0000_0000);
    rchk("mask", A_MSK, 32'hffff_ffff);
    rchk("prio", A_PRI, 32'h0000_007f);
    rchk("wpend", A_WP, 32'h0000_0000);
    rchk("windex", A_WI, 32'h0000_0000);
    rchk("unmapped", 32'h4a00_0020, 32'h0000_0000);
    pulse(32'h8100_0049);
    rchk("latch", A_LAT, 32'h8000_0009);
    outs(1'b0, 1'b0);
    wr(A_LAT, 32'h0000_0008);
    rchk("latch", A_LAT, 32'h8000_0001);
    wr(A_LAT, 32'hffff_ffff);
    rchk("latch", A_LAT, 32'h0000_0000);
    wr(A_MSK, 32'hffff_fff0);
    source_req <= 32'h0000_0005;
    repeat (3) @(posedge clock);
    outs(1'b0, 1'b1);
    rchk("wpend", A_WP, 32'h0000_0001);
    rchk("windex", A_WI, 32'h0000_0000);
    source_req <= 32'h0000_0000;
    wr(A_LAT, 32'h0000_0001);
    wr(A_WP, 32'h0000_0001);
    rchk("prio", A_PRI, 32'h0000_00ff);
    rchk("windex", A_WI, 32'h0000_0002);
    wr(A_LAT, 32'h0000_0004);
    wr(A_WP, 32'h0000_0004);
    rchk("prio", A_PRI, 32'h0000_01ff);
    rchk("wpend", A_WP, 32'h0000_0000);
    outs(1'b0, 1'b0);
    wr(A_PRI, 32'h0000_007e);
    source_req <= 32'h0000_000f;
    repeat (3) @(posedge clock);
    rchk("windex", A_WI, 32'h0000_0000);
    prev = 0;
    foreach (sv[i]) begin
      wr(A_PRI, 32'h0000_007e | (32'(sv[i]) << 7));
      wr(A_WP, 32'h0000_0001 << prev);
      rchk("windex", A_WI, 32'(sv[i]));
      rchk("prio", A_PRI, 32'h0000_007e | (32'(sv[i]) << 7));
      prev = sv[i];
    end
    source_req <= 32'h0000_0000;
    wr(A_LAT, 32'h0000_000f);
    wr(A_WP, 32'h0000_0001);
    rchk("wpend", A_WP, 32'h0000_0000);
    wr(A_PRI, 32'h0000_067f);
    wr(A_MSK, 32'hffff_fc0f);
    pulse(32'h0000_0310);
    rchk("windex", A_WI, 32'h0000_0004);
    wr(A_LAT, 32'h0000_0010);
    wr(A_WP, 32'h0000_0010);
    rchk("prio", A_PRI, 32'h0008_067f);
    rchk("windex", A_WI, 32'h0000_0008);
    wr(A_LAT, 32'h0000_0100);
    wr(A_WP, 32'h0000_0100);
    rchk("prio", A_PRI, 32'h0008_007f);
    rchk("windex", A_WI, 32'h0000_0009);
    wr(A_LAT, 32'h0000_0200);
    wr(A_WP, 32'h0000_0200);
    rchk("prio", A_PRI, 32'h0008_007f);
    wr(A_MAP, 32'h0000_0400);
    rchk("map", A_MAP, 32'h0000_0400);
    wr(A_MSK, 32'hffff_fbff);
    pulse(32'h0000_0400);
    outs(1'b1, 1'b0);
    rchk("wpend", A_WP, 32'h0000_0000);
    rchk("latch", A_LAT, 32'h0000_0400);
    wr(A_LAT, 32'h0000_0400);
    @(posedge clock);
    outs(1'b0, 1'b0);
    wr(A_MAP, 32'h0000_0000);
    wr(A_PRI, 32'h0000_003f);
    wr(A_MSK, 32'h0fff_ffff);
    pulse(32'h1000_0000);
    rchk("windex", A_WI, 32'h0000_001c);
    rchk("wpend", A_WP, 32'h1000_0000);
    wr(A_LAT, 32'h1000_0000);
    wr(A_WP, 32'h1000_0000);
    rchk("prio", A_PRI, 32'h0002_003f);
    check("fiq entries", {24'h0, fiq_entries}, 32'h0000_0001);
    check("irq entries", {24'h0, irq_entries}, 32'h0000_0004);
    results();
  end
endmodule : tb
